// ==== bcdudc_digit.sv ====
// One BCD decade of the up/down counter.
// Assumes the parent chains step enables through the terminal flags.
`timescale 1ns/1ps
`default_nettype none
module bcdudc_digit
	import bcdudc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       clkEn,
	input  wire logic       clear,
	input  wire logic       load,
	input  wire logic [3:0] loadVal,
	input  wire logic       step,
	input  wire logic       up,
	output logic      [3:0] value,
	output logic            term
);
	logic [3:0] value_nxt;

	assign term = up ? (value == DIG_MAX) : (value == DIG_ZERO);
	assign value_nxt = up ? ((value == DIG_MAX) ? DIG_ZERO : value + 4'h1)
		: ((value == DIG_ZERO) ? DIG_MAX : value - 4'h1);

	always_ff @(posedge clk) begin
		if (sys_rst)
			value <= DIG_ZERO;
		else if (clkEn) begin
			if (clear)
				value <= DIG_ZERO;
			else if (load)
				value <= loadVal;
			else if (step)
				value <= value_nxt;
		end
	end
endmodule
`default_nettype wire

// ==== bcdudc_pkg.sv ====
// Shared constants for the four-decade BCD up/down counter with display scan.
// Assumes a 20 MHz system clock and decoded three-level pad codes.
package bcdudc_pkg;
	localparam int CLK_HZ   = 20_000_000;
	localparam int SCAN_HZ  = 2500;
	localparam int SCAN_DUTY = 25;
	localparam int SCAN_PERIOD_CYC = CLK_HZ / SCAN_HZ;
	localparam int DIGITS   = 4;
	localparam int DIG_W    = 4;
	localparam int CNT_W    = DIGITS * DIG_W;

	// Three-level pad codes
	localparam logic [1:0] LVL_LOW  = 2'h0;
	localparam logic [1:0] LVL_OPEN = 2'h1;
	localparam logic [1:0] LVL_HIGH = 2'h2;

	localparam logic [1:0] PH_TOP    = 2'h3;
	localparam logic [1:0] PH_BOTTOM = 2'h0;
	localparam logic [3:0] DIG_MAX   = 4'h9;
	localparam logic [3:0] DIG_ZERO  = 4'h0;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_MAX  = 16'h9999;

	// Wishbone byte addresses
	localparam int ADR_W = 8;
	localparam logic [7:0] ADR_CTRL   = 8'h00;
	localparam logic [7:0] ADR_COUNT  = 8'h04;
	localparam logic [7:0] ADR_PRESET = 8'h08;
	localparam logic [7:0] ADR_LATCH  = 8'h0c;
	localparam logic [7:0] ADR_STATUS = 8'h10;
	localparam int CTRL_EXT_SCAN = 0;
	localparam logic CTRL_EXT_SCAN_RST = 1'h0;

	// gfedcba segment patterns for 0..9
	localparam logic [6:0] SEG_TABLE [0:9] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66,
		7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};

	typedef enum logic {ST_IDLE, ST_LOAD} bcdudc_state_t;
endpackage

// ==== bcdudc_switches.sv ====
// Far-side model: thumbwheel switches strobed by the digit lines, isolated by diodes.
// Assumes a common-anode part, so unselected BCD pins are pulled down to zero.
`timescale 1ns/1ps
`default_nettype none
module bcdudc_switches (
	input  wire logic [3:0]  digitOut,
	input  wire logic [3:0]  bcdOut,
	input  wire logic        bcdOe,
	input  wire logic [15:0] switchVal,
	output logic      [3:0]  bcdIn
);
	// The strobed switch drives its digit, high-true, while bcdOe is low; with bcdOe high bcdIn follows bcdOut
	always_comb begin
		if (bcdOe)
			bcdIn = bcdOut;
		else begin
			case (digitOut)
				4'h8: bcdIn = switchVal[15:12];
				4'h4: bcdIn = switchVal[11:8];
				4'h2: bcdIn = switchVal[7:4];
				4'h1: bcdIn = switchVal[3:0];
				default: bcdIn = 4'h0;
			endcase
		end
	end
endmodule
`default_nettype wire

// ==== bcdudc_top.sv ====
// Four-decade BCD up/down counter with latches, preset register and display scan.
// Assumes pin inputs are asynchronous and three-level pins arrive as pad codes.
`timescale 1ns/1ps
`default_nettype none
module bcdudc_top
	import bcdudc_pkg::*;
#(
	parameter int SCAN_PERIOD    = SCAN_PERIOD_CYC,
	parameter bit COMMON_CATHODE = 1'b0
)(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        clkEn,
	input  wire logic        countIn,
	input  wire logic        upDown,
	input  wire logic        storeN,
	input  wire logic        resetN,
	input  wire logic        scanIn,
	input  wire logic [1:0]  loadCounterSelect,
	input  wire logic [1:0]  presetRegisterSelect,
	input  wire logic [1:0]  displayCtrl,
	input  wire logic [3:0]  bcdIn,
	output logic      [3:0]  bcdOut,
	output logic             bcdOe,
	output logic      [6:0]  segOut,
	output logic      [3:0]  digitOut,
	output logic             carryBorrow,
	output logic             equalN,
	output logic             zeroN,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	output logic             wb_ack_o
);
	localparam int SCAN_PULSE = (SCAN_PERIOD / SCAN_DUTY < 1) ? 1 : SCAN_PERIOD / SCAN_DUTY;
	localparam int OSC_W = $clog2(SCAN_PERIOD);
	localparam int PIN_W = 15;
	localparam logic [OSC_W-1:0] OSC_LAST  = OSC_W'(SCAN_PERIOD - 1);
	localparam logic [OSC_W-1:0] OSC_PULSE = OSC_W'(SCAN_PULSE);
	localparam logic [OSC_W-1:0] OSC_ZERO  = '0;

	// Pin synchroniser, two stages
	logic [PIN_W-1:0] pinMeta_r;
	logic [PIN_W-1:0] pinSync_r;
	logic             countPrev_r;
	logic             scanPrev_r;
	logic             lcHighPrev_r;
	logic             lrHighPrev_r;
	wire  [PIN_W-1:0] pinRaw = {countIn, upDown, storeN, resetN, scanIn,
		loadCounterSelect, presetRegisterSelect, displayCtrl, bcdIn};

	wire       countSync  = pinSync_r[14];
	wire       upSync     = pinSync_r[13];
	wire       storeLow   = !pinSync_r[12];
	wire       resetLow   = !pinSync_r[11];
	wire       scanSync   = pinSync_r[10];
	wire [1:0] lcLvl      = pinSync_r[9:8];
	wire [1:0] lrLvl      = pinSync_r[7:6];
	wire [1:0] dispLvl    = pinSync_r[5:4];
	wire [3:0] bcdSync    = pinSync_r[3:0];

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pinMeta_r    <= '0;
			pinSync_r    <= '0;
			countPrev_r  <= 1'b0;
			scanPrev_r   <= 1'b0;
			lcHighPrev_r <= 1'b0;
			lrHighPrev_r <= 1'b0;
		end else if (clkEn) begin
			pinMeta_r    <= pinRaw;
			pinSync_r    <= pinMeta_r;
			countPrev_r  <= countSync;
			scanPrev_r   <= scanSync;
			lcHighPrev_r <= (lcLvl == LVL_HIGH);
			lrHighPrev_r <= (lrLvl == LVL_HIGH);
		end
	end

	// State
	bcdudc_state_t    state_r;
	logic [1:0]       phase_r;
	logic [OSC_W-1:0] oscCnt_r;
	logic             ldCtr_r;
	logic             ldReg_r;
	logic             lcSeen_r;
	logic             lrSeen_r;
	logic [15:0]      latch_r;
	logic [15:0]      preset_r;
	logic             ctrlExtScan_r;
	logic             ackQ_r;

	wire loading  = (state_r == ST_LOAD);
	wire lcHigh   = (lcLvl == LVL_HIGH);
	wire lrHigh   = (lrLvl == LVL_HIGH);
	wire lcRise   = lcHigh && !lcHighPrev_r;
	wire lrRise   = lrHigh && !lrHighPrev_r;
	wire dispOff  = (lrLvl == LVL_LOW);
	wire oscStop  = dispOff && !loading;
	wire useExt   = ctrlExtScan_r && !loading;
	wire tickInt  = (oscCnt_r == OSC_LAST) && !oscStop;
	wire pulseInt = (oscCnt_r < OSC_PULSE);
	wire scanRise = scanSync && !scanPrev_r;
	wire tick     = useExt ? scanRise : tickInt;
	wire blankPulse = useExt ? scanSync : pulseInt;
	wire anySeen  = lcSeen_r || lrSeen_r;
	wire startLoad = !loading && anySeen;
	wire passEnd  = loading && tick && (phase_r == PH_BOTTOM);
	wire again    = anySeen || lcHigh || lrHigh;
	wire passStart = startLoad || (passEnd && again);
	wire loadTick = loading && tick;

	// Preset data path; reset forces zero
	wire [3:0] bcdTrue    = COMMON_CATHODE ? ~bcdSync : bcdSync;
	wire [3:0] presetData = resetLow ? DIG_ZERO : bcdTrue;

	// Counter decades
	wire        countRise = countSync && !countPrev_r;
	wire        inhibit   = resetLow || (loading && ldCtr_r);
	wire [4:0]  stepChain;
	wire [3:0]  termDig;
	wire [15:0] counterVal;
	assign stepChain[0] = countRise && !inhibit;

	genvar gi;
	generate
		for (gi = 0; gi < DIGITS; gi++) begin : gDig
			assign stepChain[gi+1] = stepChain[gi] && termDig[gi];
			bcdudc_digit uDigit (
				.clk     (clk),
				.sys_rst (sys_rst),
				.clkEn   (clkEn),
				.clear   (resetLow),
				.load    (loadTick && ldCtr_r && (phase_r == 2'(gi))),
				.loadVal (presetData),
				.step    (stepChain[gi]),
				.up      (upSync),
				.value   (counterVal[gi*DIG_W +: DIG_W]),
				.term    (termDig[gi])
			);
		end
	endgenerate

	// Leading zero detection over the latches, top digit downward
	wire [4:0] lzRun;
	assign lzRun[4] = 1'b1;
	generate
		for (gi = 0; gi < DIGITS; gi++) begin : gLz
			assign lzRun[gi] = lzRun[gi+1] && (latch_r[gi*DIG_W +: DIG_W] == DIG_ZERO);
		end
	endgenerate

	wire [3:0] curDigit = latch_r[phase_r*DIG_W +: DIG_W];
	wire       lzBlank  = lzRun[phase_r] && (phase_r != PH_BOTTOM) && (dispLvl != LVL_LOW);
	wire       digitOn  = !blankPulse && !dispOff;
	wire       segOn    = digitOn && (dispLvl != LVL_HIGH) && !lzBlank && (curDigit <= DIG_MAX);
	wire       portOut  = (lcLvl == LVL_OPEN) && (lrLvl == LVL_OPEN) && !loading;

	wire [1:0]       phase_nxt  = startLoad ? PH_TOP : (tick ? phase_r - 2'h1 : phase_r);
	wire [OSC_W-1:0] oscCnt_nxt = startLoad ? OSC_ZERO : (oscStop ? oscCnt_r
		: (tickInt ? OSC_ZERO : oscCnt_r + OSC_W'(1)));
	wire lcSeen_nxt = lcRise || (lcSeen_r && !passStart);
	wire lrSeen_nxt = lrRise || (lrSeen_r && !passStart);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_r  <= ST_IDLE;
			phase_r  <= PH_TOP;
			oscCnt_r <= OSC_ZERO;
			ldCtr_r  <= 1'b0;
			ldReg_r  <= 1'b0;
			lcSeen_r <= 1'b0;
			lrSeen_r <= 1'b0;
		end else if (clkEn) begin
			phase_r  <= phase_nxt;
			oscCnt_r <= oscCnt_nxt;
			lcSeen_r <= lcSeen_nxt;
			lrSeen_r <= lrSeen_nxt;
			unique case (state_r)
				ST_IDLE: if (startLoad) begin
					state_r <= ST_LOAD;
					ldCtr_r <= lcSeen_r;
					ldReg_r <= lrSeen_r;
				end
				ST_LOAD: if (passEnd) begin
					if (again) begin
						ldCtr_r <= lcSeen_r || lcHigh;
						ldReg_r <= lrSeen_r || lrHigh;
					end else begin
						state_r <= ST_IDLE;
						ldCtr_r <= 1'b0;
						ldReg_r <= 1'b0;
					end
				end
			endcase
		end
	end

	// Register, latches and outputs
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			preset_r    <= CNT_ZERO;
			latch_r     <= CNT_ZERO;
			carryBorrow <= 1'b0;
			equalN      <= 1'b1;
			zeroN       <= 1'b1;
			digitOut    <= 4'h0;
			segOut      <= 7'h00;
			bcdOut      <= 4'h0;
			bcdOe       <= 1'b0;
		end else if (clkEn) begin
			if (loadTick && ldReg_r)
				preset_r[phase_r*DIG_W +: DIG_W] <= presetData;
			if (storeLow)
				latch_r <= counterVal;
			carryBorrow <= stepChain[DIGITS];
			equalN      <= (counterVal != preset_r);
			zeroN       <= (counterVal != CNT_ZERO);
			digitOut    <= digitOn ? (4'h1 << phase_r) : 4'h0;
			segOut      <= segOn ? SEG_TABLE[curDigit] : 7'h00;
			bcdOut      <= curDigit;
			bcdOe       <= portOut;
		end
	end

	// Wishbone slave, one wait state
	wire        wbHit   = wb_cyc_i && wb_stb_i && !ackQ_r;
	wire        wbWrite = wbHit && wb_we_i && wb_sel_i[0] && (wb_adr_i == ADR_CTRL);
	wire [31:0] statusWord = {27'h0, !zeroN, !equalN, phase_r, loading};
	wire [31:0] rdData =
		(wb_adr_i == ADR_CTRL)   ? {31'h0, ctrlExtScan_r} :
		(wb_adr_i == ADR_COUNT)  ? {16'h0, counterVal} :
		(wb_adr_i == ADR_PRESET) ? {16'h0, preset_r} :
		(wb_adr_i == ADR_LATCH)  ? {16'h0, latch_r} :
		(wb_adr_i == ADR_STATUS) ? statusWord : 32'h0;
	assign wb_ack_o = ackQ_r;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ackQ_r        <= 1'b0;
			wb_dat_o      <= 32'h0;
			ctrlExtScan_r <= CTRL_EXT_SCAN_RST;
		end else if (clkEn) begin
			ackQ_r <= wbHit;
			if (wbHit)
				wb_dat_o <= rdData;
			if (wbWrite)
				ctrlExtScan_r <= wb_dat_i[CTRL_EXT_SCAN];
		end
	end

	// Checks
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_phase_order: assert property (clkEn && tick && !startLoad |=> phase_r == $past(phase_r) - 2'h1)
		else $error("scan phase did not step downward");
	a_strobe_blank: assert property (clkEn && blankPulse |=> digitOut == 4'h0)
		else $error("digit strobe active during scan pulse");
	a_ext_blank: assert property (clkEn && useExt && scanSync |=> digitOut == 4'h0)
		else $error("digit strobe active while external scan high");
	a_count_step: assert property (clkEn && countRise && !inhibit && upSync && counterVal[3:0] != DIG_MAX
		|=> counterVal[3:0] == $past(counterVal[3:0]) + 4'h1)
		else $error("counter did not increment");
	a_count_inhibit: assert property (clkEn && resetLow |=> counterVal == CNT_ZERO)
		else $error("reset did not clear the counter");
	a_store_copy: assert property (clkEn && storeLow |=> latch_r == $past(counterVal))
		else $error("latch not loaded from counter");
	a_bcd_float: assert property (clkEn && (lcLvl == LVL_LOW || lrLvl == LVL_LOW) |=> !bcdOe)
		else $error("BCD port driven while a load input is low");
	a_load_start: assert property (clkEn && startLoad |=> loading && phase_r == PH_TOP && oscCnt_r == OSC_ZERO)
		else $error("load did not reset scan to the top digit");
	a_carry_wrap: assert property (clkEn && countRise && !inhibit && !upSync && counterVal == CNT_ZERO
		|=> carryBorrow && counterVal == CNT_MAX)
		else $error("borrow pulse missing on downward wrap");
	a_zero_flag: assert property (clkEn && !sys_rst && counterVal == CNT_ZERO |=> !zeroN)
		else $error("zero output not asserted");
	a_display_off: assert property (clkEn && dispOff |=> digitOut == 4'h0 && segOut == 7'h00)
		else $error("display driven while switched off");
endmodule
`default_nettype wire

// ==== tb_bcdudc_top.sv ====
// Self-checking bench for the BCD up/down counter with an integer reference model.
// Assumes a shortened scan period of 50 clocks and a common-anode build.
`timescale 1ns/1ps
`default_nettype none
module tb_bcdudc_top import bcdudc_pkg::*; ;
	logic        clk = 0, sys_rst = 1, countIn = 0, upDown = 1, storeN = 1, resetN = 1, scanIn = 0;
	logic [1:0]  lcSel = LVL_OPEN, lrSel = LVL_OPEN, dispCtrl = LVL_OPEN;
	logic [15:0] swVal = 16'h0000;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat;
	logic        we = 0, cyc = 0, stb = 0;
	wire logic [3:0] bcdIn, bcdOut, digitOut;
	wire logic [6:0] segOut;
	wire logic       bcdOe, carryBorrow, equalN, zeroN, ack;
	wire logic [31:0] datO;
	int n_mismatch = 0, compares = 0, cntM = 0, carM = 0, carSeen = 0, latM = 0, t, p0, d;
	bit          lz;
	int seed = 32'haef5ed48;

	bcdudc_top #(.SCAN_PERIOD(50), .COMMON_CATHODE(1'b0)) dut (.clk(clk), .sys_rst(sys_rst), .clkEn(1'b1),
		.countIn(countIn), .upDown(upDown), .storeN(storeN), .resetN(resetN), .scanIn(scanIn),
		.loadCounterSelect(lcSel), .presetRegisterSelect(lrSel), .displayCtrl(dispCtrl), .bcdIn(bcdIn),
		.bcdOut(bcdOut), .bcdOe(bcdOe), .segOut(segOut), .digitOut(digitOut), .carryBorrow(carryBorrow),
		.equalN(equalN), .zeroN(zeroN), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(datO), .wb_we_i(we),
		.wb_sel_i(4'hf), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack));
	bcdudc_switches sw (.digitOut(digitOut), .bcdOut(bcdOut), .bcdOe(bcdOe), .switchVal(swVal), .bcdIn(bcdIn));

	initial begin
		forever #25 clk = ~clk;
	end
	always @(posedge clk) if (carryBorrow === 1'b1) carSeen++;

	function automatic logic [15:0] bcd(input int v);
		return {4'(v / 1000 % 10), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
	endfunction
	task automatic chkReg(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chkPin(input string nm, input logic [3:0] e, input logic [3:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One classic cycle; the request stands until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (ack !== 1'b1 && t < 50);
		rdat = datO;
		if (t >= 50) n_mismatch++;
		cyc <= 0; stb <= 0; we <= 0;
	endtask
	task automatic pulse(input logic up);
		@(posedge clk); upDown <= up;
		repeat (4) @(posedge clk); countIn <= 1;
		repeat (4) @(posedge clk); countIn <= 0;
		repeat (4) @(posedge clk);
		if (resetN) begin
			if (!up && cntM == 0) carM++;
			cntM = up ? (cntM + 1) % 10000 : (cntM + 9999) % 10000;
			if (up && cntM == 0) carM++;
		end
	endtask
	// Short high pulse on a load select, then wait for the pass to end
	task automatic load(input logic toReg, input int v);
		@(posedge clk); swVal <= bcd(v);
		if (toReg) lrSel <= LVL_HIGH; else lcSel <= LVL_HIGH;
		repeat (20) @(posedge clk);
		lrSel <= LVL_OPEN; lcSel <= LVL_OPEN;
		for (int k = 0; k < 200; k++) begin
			wb(0, ADR_STATUS, 0);
			if (rdat[0] === 1'b0) break;
		end
		if (!toReg) cntM = v;
	endtask
	task automatic chkCount();
		wb(0, ADR_COUNT, 0); chkReg("count", bcd(cntM), rdat);
	endtask
	// Wait for the strobe of digit i (0 = top), then let it settle two clocks
	task automatic scan(input int i);
		t = 0;
		while (digitOut !== 4'(8 >> i) && t < 300) begin
			@(posedge clk);
			t++;
		end
		if (t >= 300) n_mismatch++;
		repeat (2) @(posedge clk);
	endtask
	task automatic finish_test();
		$display("Compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		#1000000;
		n_mismatch++;
		finish_test();
	end
	initial begin
		repeat (6) @(posedge clk); sys_rst <= 0;
		repeat (4) @(posedge clk);
		wb(0, 8'h20, 0); chkReg("unmapped", 0, rdat);
		wb(0, ADR_CTRL, 0); chkReg("ctrl", {31'h0, CTRL_EXT_SCAN_RST}, rdat);
		wb(1, ADR_CTRL, 1); wb(0, ADR_CTRL, 0); chkReg("ctrl", 1, rdat);
		wb(0, ADR_STATUS, 0); p0 = rdat[2:1];
		scanIn <= 1; repeat (10) @(posedge clk);
		chkPin("digitOut", 0, digitOut);
		scanIn <= 0; repeat (10) @(posedge clk);
		chkPin("digitOut", 4'(1 << ((p0 + 3) % 4)), digitOut);
		wb(0, ADR_STATUS, 0); chkReg("phase", (p0 + 3) % 4, rdat[2:1]);
		wb(1, ADR_CTRL, 0);
		chkPin("zeroN", 0, {3'h0, zeroN});
		load(0, 9997); chkCount();
		wb(0, ADR_PRESET, 0); chkReg("preset", 0, rdat);
		storeN <= 0;
		repeat (5) pulse(1);
		chkCount();
		chkReg("carry", carM, carSeen);
		wb(0, ADR_LATCH, 0); chkReg("latch", bcd(cntM), rdat);
		storeN <= 1; latM = cntM;
		repeat (3) pulse(0);
		chkCount();
		chkReg("carry", carM, carSeen);
		wb(0, ADR_LATCH, 0); chkReg("latch", bcd(latM), rdat);
		for (int k = 0; k < 8; k++) pulse(1'($random(seed)));
		chkCount();
		load(1, cntM);
		wb(0, ADR_PRESET, 0); chkReg("preset", bcd(cntM), rdat);
		chkCount();
		chkPin("equalN", 0, {3'h0, equalN});
		storeN <= 0; repeat (6) @(posedge clk); storeN <= 1; latM = cntM;
		lz = 1;
		for (int i = 0; i < 4; i++) begin
			scan(i);
			d = latM / (10 ** (3 - i)) % 10;
			lz = lz && (d == 0);
			chkPin("digitOut", 4'(8 >> i), digitOut);
			chkPin("bcdOut", 4'(d), bcdOut);
			chkPin("bcdOe", 1, {3'h0, bcdOe});
			chkReg("segOut", (lz && i < 3) ? 0 : {25'h0, SEG_TABLE[d]}, {25'h0, segOut});
		end
		dispCtrl <= LVL_HIGH; repeat (60) @(posedge clk);
		chkReg("segOut", 0, {25'h0, segOut});
		dispCtrl <= LVL_OPEN;
		resetN <= 0; repeat (4) @(posedge clk);
		pulse(1);
		resetN <= 1; cntM = 0; repeat (4) @(posedge clk);
		chkCount();
		chkPin("zeroN", 0, {3'h0, zeroN});
		lrSel <= LVL_LOW; repeat (60) @(posedge clk);
		chkPin("bcdOe", 0, {3'h0, bcdOe});
		chkPin("digitOut", 0, digitOut);
		chkReg("segOut", 0, {25'h0, segOut});
		pulse(1); chkCount();
		lrSel <= LVL_OPEN; lcSel <= LVL_LOW; repeat (10) @(posedge clk);
		chkPin("bcdOe", 0, {3'h0, bcdOe});
		chkCount();
		lcSel <= LVL_OPEN;
		storeN <= 0; repeat (6) @(posedge clk); storeN <= 1;
		scan(0); chkReg("segTop", 0, {25'h0, segOut});
		dispCtrl <= LVL_LOW; repeat (60) @(posedge clk);
		scan(0); chkReg("segTop", {25'h0, SEG_TABLE[0]}, {25'h0, segOut});
		finish_test();
	end
endmodule
`default_nettype wire
